//--- hw/lmcs_pkg.sv
// register map, field positions and timing constants of the MAC control/status bank
package lmcs_pkg;
  localparam logic [7:0] OFS_NAC  = 8'h30;
  localparam logic [7:0] OFS_IEM  = 8'h38;
  localparam logic [7:0] OFS_DFC  = 8'h40;
  localparam logic [7:0] OFS_SPC  = 8'h48;
  localparam logic [7:0] OFS_TMR  = 8'h58;
  localparam logic [7:0] OFS_WCS  = 8'h68;
  localparam logic [7:0] OFS_WPP  = 8'h70;
  localparam logic [7:0] OFS_WAUX = 8'h88;
  localparam logic [7:0] OFS_ISTS = 8'h28;

  // network access control fields
  localparam int NAC_SQE_OFF = 19;
  localparam int NAC_TR_LO   = 14;
  localparam int NAC_TX_RUN  = 13;
  localparam int NAC_FC      = 12;
  localparam int NAC_OM_LO   = 10;
  localparam int NAC_MM      = 7;
  localparam int NAC_PR      = 6;
  localparam int NAC_SBC     = 5;
  localparam int NAC_PB      = 3;
  localparam int NAC_RX_RUN  = 1;
  localparam logic [31:0] NAC_RST  = 32'h0008_0040;
  localparam logic [31:0] NAC_MASK = 32'h0008_FCEA;

  // interrupt enable and status
  localparam int IE_NORM = 16;
  localparam int IE_ABN  = 15;
  localparam logic [14:0] IE_SRC_MASK  = 15'h2BEF;
  localparam logic [14:0] NORM_SRC_SET = 15'h0045;

  // dropped frame counter
  localparam int DFC_OVF = 16;

  // serial pin control
  localparam int SPC_MDI = 19;
  localparam int SPC_MMC = 18;
  localparam int SPC_MDO = 17;
  localparam int SPC_MDC = 16;
  localparam int SPC_SRC = 14;
  localparam int SPC_SWC = 13;
  localparam int SPC_SRS = 11;
  localparam int SPC_SDO = 3;
  localparam int SPC_SDI = 2;
  localparam int SPC_SCK = 1;
  localparam int SPC_SCS = 0;
  localparam logic [31:0] SPC_RST  = 32'h0004_0006;
  localparam logic [31:0] SPC_MASK = 32'h0007_6807;

  // timer
  localparam int TMR_CONT = 16;
  localparam int CLK_HZ         = 20_000_000;
  localparam int TICK_US        = 204;
  localparam int TICK_CYC       = (CLK_HZ / 1_000_000) * TICK_US;
  localparam logic [12:0] TICK_LAST = 13'(TICK_CYC - 1);

  // wake control/status
  localparam int WCS_PATTERN_CRC_SEED_SELECT = 30;
  localparam int WCS_WP_LO = 25;
  localparam int WCS_LOFF = 17;
  localparam int WCS_LON  = 16;
  localparam int WCS_WAKE_FRAME_EVENT_ENABLE = 10;
  localparam int WCS_MAGIC_FRAME_EVENT_ENABLE = 9;
  localparam int WCS_LINK_CHANGE_EVENT_ENABLE = 8;
  localparam int WCS_WFR  = 2;
  localparam int WCS_MPR  = 1;
  localparam int WCS_LSC  = 0;
  localparam logic [31:0] WCS_MASK = 32'h7E03_0700;
  localparam int WAUX_RWP = 6;

  // wake pattern table
  localparam int WPT_WORDS = 25;
  localparam logic [4:0] WPT_LAST = 5'(WPT_WORDS - 1);
  localparam logic [15:0] CRC_SEED_ONE = 16'hFFFF;
  localparam logic [15:0] CRC_SEED_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    LMCS_RX_STOP = 2'b00,
    LMCS_RX_RUN  = 2'b01,
    LMCS_RX_DRAIN = 2'b11
  } lmcs_rx_e;
endpackage

//--- hw/lmcs_pattern_ram.sv
// wake pattern table storage, 25 words, registered read
`timescale 1ns/10ps
module lmcs_pattern_ram (
  input  wire logic        clk_sys_i,  // system clock
  input  wire logic        we_i,       // write strobe
  input  wire logic [4:0]  waddr_i,    // write index
  input  wire logic [31:0] wdata_i,    // write word
  input  wire logic [4:0]  raddr_i,    // read index
  output logic      [31:0] rdata_o     // registered read word
);
  import lmcs_pkg::*;
  logic [31:0] mem [WPT_WORDS];

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule

//--- hw/lmcs_regs.sv
// control and status register bank of the LAN MAC
// Behaviour
// - bit 19 disables SQE test, reset 1; clear enables it in 10M half duplex.
// - bits 15:14 pick transmit threshold, four byte levels per speed.
// - bit 13 starts transmit when 1, stops when 0, reset 0.
// - bit 12 forces a collision during transmit, for loopback testing.
// - bits 11:10 select normal (00) or MAC loopback (01); others reserved.
// - bit 6 accepts any good frame, reset 1; bit 7 accepts all multicast.
// - bit 5 holds backoff counter while carrier is active.
// - bit 3 passes bad frames that pass the address filter.
// - clearing bit 1 stops receive after current frame; setting starts it.
// - group enables 16 and 15 gate normal and abnormal source enables.
// - 16-bit dropped-frame count plus overflow flag, both cleared on read.
// - software bit-bangs PHY management clock, data out, direction, data in.
// - bits 1, 0, 2 drive EEPROM clock, select, data; bit 3 reads it.
// - 16-bit countdown timer, 204 us tick, continuous reload with bit 16.
// - bit 30 selects CRC-16 seed FFFF, else 0000.
// - bits 29:25 enable matching of the five stored patterns.
// - link-off and link-on enables set link-change status on transitions.
// - enabled wake, magic or link events set the power event status.
// - wake status bits clear by writing 1 or power-up reset only.
// - pattern table loaded by 25 consecutive writes to one port.
// - pointer reset bit returns the pattern write pointer to the start.
// - interrupt status flags latch high and clear by writing 1.
`timescale 1ns/10ps
module lmcs_regs (
  input  wire logic        clk_sys_i,       // system clock, 20 MHz
  input  wire logic        rst_i,           // sync reset, also software reset
  input  wire logic        por_i,           // power-up reset, clears wake status
  input  wire logic        reg_wr_i,        // register write strobe
  input  wire logic        reg_rd_i,        // register read strobe
  input  wire logic [7:0]  reg_addr_i,      // byte offset
  input  wire logic [31:0] reg_wdata_i,     // write data
  output logic      [31:0] reg_rdata_o,     // read data, valid cycle after strobe
  input  wire logic [14:0] irq_event_i,     // status source pulses
  input  wire logic        drop_frame_i,    // frame lost, no descriptor
  input  wire logic        rx_frame_end_i,  // current receive frame completed
  input  wire logic        carrier_i,       // carrier sense
  input  wire logic        link_up_i,       // link status level
  input  wire logic        wake_frame_i,    // matched wake frame pulse
  input  wire logic        magic_frame_i,   // magic-pattern frame pulse
  input  wire logic        mdio_in_i,       // management data from PHY
  input  wire logic        ee_dout_i,       // EEPROM serial output
  output logic             sqe_test_en_o,   // SQE test enabled
  output logic      [1:0]  tx_fifo_threshold_o, // threshold code
  output logic             tx_run_o,        // transmit started
  output logic             forced_collide_o,// force collision
  output logic      [1:0]  loopback_select_o, // operating mode
  output logic             all_group_accept_o, // accept all multicast
  output logic             accept_any_good_o,  // promiscuous
  output logic             bad_frame_accept_o, // pass bad frames
  output logic             rx_active_o,     // receive process running
  output logic             backoff_hold_o,  // backoff counter frozen
  output logic             irq_o,           // interrupt request
  output logic             mdc_o,           // management clock
  output logic             mdio_out_o,      // management data out
  output logic             mdio_oe_n_o,     // low while driving
  output logic             ee_clk_o,        // EEPROM clock
  output logic             ee_cs_o,         // EEPROM chip select
  output logic             ee_din_o,        // data to EEPROM
  output logic             pm_event_o,      // power event status
  output logic             timer_expired_o, // timer expiry pulse
  output logic      [4:0]  pattern_enable_o,// per-pattern match enable
  output logic      [15:0] crc_seed_o,      // wake CRC-16 seed
  input  wire logic [4:0]  pat_raddr_i,     // pattern table read index
  output logic      [31:0] pat_rdata_o      // pattern table word
);
  import lmcs_pkg::*;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [31:0] nac;
  logic [16:0] iem;
  logic [14:0] ists;
  logic [15:0] drop_cnt;
  logic        drop_ovf;
  logic [31:0] spc;
  logic [16:0] tmr;
  logic [31:0] wcs;
  logic [2:0]  wake_sts;
  logic        waux_rwp;
  logic [4:0]  wp_ptr;
  logic [15:0] tmr_cnt;
  logic        tmr_active;
  logic [12:0] tick_cnt;
  logic        tick;
  logic        link_q;
  lmcs_rx_e    rx_state;
  logic [31:0] next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  wire wr_nac = reg_wr_i && hit(reg_addr_i, OFS_NAC);
  wire wr_wpp = reg_wr_i && hit(reg_addr_i, OFS_WPP);
  wire rd_dfc = reg_rd_i && hit(reg_addr_i, OFS_DFC);
  wire wr_tmr = reg_wr_i && hit(reg_addr_i, OFS_TMR);

  // ----------------------------------------------------------------
  // network access control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nac <= NAC_RST;
    end else if (wr_nac) begin
      nac <= reg_wdata_i & NAC_MASK;
    end
  end

  assign sqe_test_en_o       = ~nac[NAC_SQE_OFF];
  assign tx_fifo_threshold_o = nac[NAC_TR_LO +: 2];
  assign tx_run_o            = nac[NAC_TX_RUN];
  assign forced_collide_o    = nac[NAC_FC] & nac[NAC_TX_RUN];
  assign loopback_select_o   = nac[NAC_OM_LO +: 2];
  assign all_group_accept_o  = nac[NAC_MM];
  assign accept_any_good_o   = nac[NAC_PR];
  assign bad_frame_accept_o  = nac[NAC_PB];
  assign backoff_hold_o      = nac[NAC_SBC] & carrier_i;

  // stop only takes effect at the frame boundary, so a frame in flight is never cut
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_state <= LMCS_RX_STOP;
    end else begin
      case (rx_state)
        LMCS_RX_STOP: begin
          if (nac[NAC_RX_RUN]) rx_state <= LMCS_RX_RUN;
        end
        LMCS_RX_RUN: begin
          if (!nac[NAC_RX_RUN]) rx_state <= LMCS_RX_DRAIN;
        end
        LMCS_RX_DRAIN: begin
          if (nac[NAC_RX_RUN]) rx_state <= LMCS_RX_RUN;
          else if (rx_frame_end_i) rx_state <= LMCS_RX_STOP;
        end
        default: rx_state <= LMCS_RX_STOP;
      endcase
    end
  end
  assign rx_active_o = (rx_state != LMCS_RX_STOP);

  // ----------------------------------------------------------------
  // interrupt enables and latched status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      iem <= '0;
    end else if (reg_wr_i && hit(reg_addr_i, OFS_IEM)) begin
      iem <= {reg_wdata_i[IE_NORM:IE_ABN], reg_wdata_i[14:0] & IE_SRC_MASK};
    end
  end

  // a new event in the clearing cycle stays set
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ists <= '0;
    end else begin
      ists <= ((reg_wr_i && hit(reg_addr_i, OFS_ISTS)) ? (ists & ~reg_wdata_i[14:0]) : ists)
              | ((irq_event_i | {3'h0, timer_expired_o, 11'h0}) & IE_SRC_MASK);
    end
  end

  wire [14:0] grp_en = ({15{iem[IE_NORM]}} & NORM_SRC_SET)
                     | ({15{iem[IE_ABN]}} & ~NORM_SRC_SET);
  assign irq_o = |(ists & iem[14:0] & grp_en);

  // ----------------------------------------------------------------
  // dropped frame counter
  // ----------------------------------------------------------------
  // a drop in the read cycle restarts the count at one so it is not lost
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      drop_cnt <= '0;
      drop_ovf <= 1'b0;
    end else if (rd_dfc) begin
      drop_cnt <= {15'h0, drop_frame_i};
      drop_ovf <= 1'b0;
    end else if (drop_frame_i) begin
      drop_cnt <= drop_cnt + 16'h0001;
      if (drop_cnt == 16'hFFFF) drop_ovf <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // serial pin control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      spc <= SPC_RST;
    end else if (reg_wr_i && hit(reg_addr_i, OFS_SPC)) begin
      spc <= reg_wdata_i & SPC_MASK;
    end
  end

  wire ee_access = spc[SPC_SRS] & (spc[SPC_SRC] | spc[SPC_SWC]);
  assign mdc_o       = spc[SPC_MDC];
  assign mdio_out_o  = spc[SPC_MDO];
  assign mdio_oe_n_o = spc[SPC_MMC];
  assign ee_clk_o    = ee_access & spc[SPC_SCK];
  assign ee_cs_o     = ee_access & spc[SPC_SCS];
  assign ee_din_o    = spc[SPC_SDI];

  // ----------------------------------------------------------------
  // general-purpose timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || wr_tmr || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 13'h0001;
    end
  end
  assign tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tmr        <= '0;
      tmr_cnt    <= '0;
      tmr_active <= 1'b0;
      timer_expired_o <= 1'b0;
    end else begin
      timer_expired_o <= 1'b0;
      if (wr_tmr) begin
        tmr        <= reg_wdata_i[16:0];
        tmr_cnt    <= reg_wdata_i[15:0];
        tmr_active <= (reg_wdata_i[15:0] != 16'h0000);
      end else if (tmr_active && tick) begin
        if (tmr_cnt == 16'h0001) begin
          timer_expired_o <= 1'b1;
          tmr_cnt    <= tmr[15:0];
          tmr_active <= tmr[TMR_CONT];
        end else begin
          tmr_cnt <= tmr_cnt - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // wake control and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wcs      <= '0;
      waux_rwp <= 1'b0;
      link_q   <= 1'b0;
    end else begin
      link_q <= link_up_i;
      if (reg_wr_i && hit(reg_addr_i, OFS_WCS)) wcs <= reg_wdata_i & WCS_MASK;
      if (reg_wr_i && hit(reg_addr_i, OFS_WAUX)) waux_rwp <= reg_wdata_i[WAUX_RWP];
    end
  end

  wire link_evt = (wcs[WCS_LOFF] & link_q & ~link_up_i)
                | (wcs[WCS_LON] & ~link_q & link_up_i);
  wire wr_wcs   = reg_wr_i && hit(reg_addr_i, OFS_WCS);

  // rst_i leaves these, power-up reset or write-one clears them; set wins over write-one clear
  always_ff @(posedge clk_sys_i) begin
    if (por_i) begin
      wake_sts <= '0;
    end else begin
      wake_sts <= (wr_wcs ? (wake_sts & ~reg_wdata_i[2:0]) : wake_sts)
                  | {wake_frame_i, magic_frame_i, link_evt};
    end
  end

  assign pm_event_o = (wcs[WCS_WAKE_FRAME_EVENT_ENABLE] & wake_sts[WCS_WFR])
                    | (wcs[WCS_MAGIC_FRAME_EVENT_ENABLE] & wake_sts[WCS_MPR])
                    | (wcs[WCS_LINK_CHANGE_EVENT_ENABLE] & wake_sts[WCS_LSC]);
  assign pattern_enable_o = wcs[WCS_WP_LO +: 5];
  assign crc_seed_o = wcs[WCS_PATTERN_CRC_SEED_SELECT] ? CRC_SEED_ONE : CRC_SEED_ZERO;

  // ----------------------------------------------------------------
  // wake pattern port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || waux_rwp) begin
      wp_ptr <= '0;
    end else if (wr_wpp) begin
      wp_ptr <= (wp_ptr == WPT_LAST) ? 5'h00 : wp_ptr + 5'h01;
    end
  end

  lmcs_pattern_ram u_ram (
    .clk_sys_i (clk_sys_i),
    .we_i      (wr_wpp && !waux_rwp),
    .waddr_i   (wp_ptr),
    .wdata_i   (reg_wdata_i),
    .raddr_i   (pat_raddr_i),
    .rdata_o   (pat_rdata_o)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (hit(reg_addr_i, OFS_NAC)) begin
      next_rdata = nac;
    end else if (hit(reg_addr_i, OFS_ISTS)) begin
      next_rdata = {15'h0, |(ists & NORM_SRC_SET), |(ists & ~NORM_SRC_SET), ists};
    end else if (hit(reg_addr_i, OFS_IEM)) begin
      next_rdata = {15'h0, iem};
    end else if (hit(reg_addr_i, OFS_DFC)) begin
      next_rdata = {15'h0, drop_ovf, drop_cnt};
    end else if (hit(reg_addr_i, OFS_SPC)) begin
      next_rdata = spc;
      next_rdata[SPC_MDI] = mdio_in_i;
      next_rdata[SPC_SDO] = ee_dout_i;
    end else if (hit(reg_addr_i, OFS_TMR)) begin
      next_rdata = {15'h0, tmr[TMR_CONT], tmr_cnt};
    end else if (hit(reg_addr_i, OFS_WCS)) begin
      next_rdata = wcs | {29'h0, wake_sts};
    end else if (hit(reg_addr_i, OFS_WAUX)) begin
      next_rdata = {25'h0, waux_rwp, 6'h00};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  dfc_read_clear_a: assert property (rd_dfc && !drop_frame_i |=> drop_cnt == 16'h0000 && !drop_ovf) else $error("counter not cleared by read");
  dfc_wrap_a: assert property (drop_frame_i && !rd_dfc && drop_cnt == 16'hFFFF |=> drop_ovf) else $error("overflow not flagged");
  irq_gate_a: assert property (!iem[IE_NORM] && !iem[IE_ABN] |-> !irq_o) else $error("irq without group enable");
  ists_sticky_a: assert property (ists[0] && !reg_wr_i |=> ists[0]) else $error("status flag lost");
  rx_stop_hold_a: assert property (rx_state == LMCS_RX_DRAIN && !rx_frame_end_i && !nac[NAC_RX_RUN] |=> rx_active_o) else $error("receive stopped mid-frame");
  tmr_tick_a: assert property (tick |=> !tick [*8]) else $error("tick spacing wrong");
  wp_reset_a: assert property (waux_rwp |=> wp_ptr == 5'h00) else $error("pointer not reset");
  wp_wrap_a: assert property (wr_wpp && !waux_rwp && wp_ptr == WPT_LAST |=> wp_ptr == 5'h00) else $error("pointer not wrapped");
  link_rise_a: assert property (wcs[WCS_LON] && !link_q && link_up_i && !por_i |=> wake_sts[WCS_LSC]) else $error("link change missed");
  crc_seed_a: assert property (wcs[WCS_PATTERN_CRC_SEED_SELECT] |-> crc_seed_o == CRC_SEED_ONE) else $error("seed wrong");

  rx_drain_c: cover property (rx_state == LMCS_RX_DRAIN ##1 rx_state == LMCS_RX_STOP);
  tmr_exp_c: cover property (timer_expired_o);
  irq_c: cover property (!irq_o ##1 irq_o);
  dfc_ovf_c: cover property (drop_ovf);
endmodule

//--- sim/lmcs_serial_peer.sv
// behavioural far side of the serial pins: PHY management data and EEPROM
`timescale 1ns/10ps
module lmcs_serial_peer (
  input  wire logic mdio_out_i,  // device data out
  input  wire logic mdio_oe_n_i, // low while device drives
  input  wire logic ee_clk_i,    // EEPROM clock
  input  wire logic ee_cs_i,     // EEPROM select
  input  wire logic ee_din_i,    // data into EEPROM
  output logic      mdio_o,      // data seen by device
  output logic      ee_dout_o    // EEPROM serial output
);
  logic ee_bit = 1'h1;
  // phy answers inverted data once the device lets go of the line
  assign mdio_o = mdio_oe_n_i ? ~mdio_out_i : mdio_out_i;
  // eeprom takes data on a rising clock, output idles high unselected
  always @(posedge ee_clk_i) if (ee_cs_i) ee_bit <= ee_din_i;
  assign ee_dout_o = ee_cs_i ? ee_bit : 1'h1;
endmodule

//--- sim/lan_mac_control_status_regs_bench.sv
// self-checking bench of the MAC control/status register bank
`timescale 1ns/10ps
module lan_mac_control_status_regs_bench;
  import lmcs_pkg::*;
  logic clk_sys_i = 1'h0, rst_i = 1'h1, por_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic drop_frame_i = 1'h0, rx_frame_end_i = 1'h0, carrier_i = 1'h0, link_up_i = 1'h0;
  logic wake_frame_i = 1'h0, magic_frame_i = 1'h0, mdio_in_i, ee_dout_i;
  logic sqe_test_en_o, tx_run_o, forced_collide_o, all_group_accept_o, accept_any_good_o;
  logic bad_frame_accept_o, rx_active_o, backoff_hold_o, irq_o, mdc_o, mdio_out_o;
  logic mdio_oe_n_o, ee_clk_o, ee_cs_o, ee_din_o, pm_event_o, timer_expired_o;
  logic [1:0]  tx_fifo_threshold_o, loopback_select_o;
  logic [4:0]  pattern_enable_o, pat_raddr_i = 5'h00;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [14:0] irq_event_i = 15'h0000;
  logic [15:0] crc_seed_o;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, pat_rdata_o;
  int          num_errors = 0, checks_done = 0, n;

  always #25 clk_sys_i = ~clk_sys_i;

  lmcs_regs u_lmcs_regs (.clk_sys_i, .rst_i, .por_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .irq_event_i, .drop_frame_i, .rx_frame_end_i, .carrier_i,
    .link_up_i, .wake_frame_i, .magic_frame_i, .mdio_in_i, .ee_dout_i, .sqe_test_en_o,
    .tx_fifo_threshold_o, .tx_run_o, .forced_collide_o, .loopback_select_o,
    .all_group_accept_o, .accept_any_good_o, .bad_frame_accept_o, .rx_active_o,
    .backoff_hold_o, .irq_o, .mdc_o, .mdio_out_o, .mdio_oe_n_o, .ee_clk_o, .ee_cs_o,
    .ee_din_o, .pm_event_o, .timer_expired_o, .pattern_enable_o, .crc_seed_o,
    .pat_raddr_i, .pat_rdata_o);

  lmcs_serial_peer u_lmcs_serial_peer (.mdio_out_i(mdio_out_o), .mdio_oe_n_i(mdio_oe_n_o),
    .ee_clk_i(ee_clk_o), .ee_cs_i(ee_cs_o), .ee_din_i(ee_din_o), .mdio_o(mdio_in_i),
    .ee_dout_o(ee_dout_i));

  // --------------------------------------------------------------
  // access and compare tasks
  // --------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(negedge clk_sys_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'h1, a, d};
    @(negedge clk_sys_i);
    reg_wr_i = 1'h0;
  endtask
  // read data is registered, so it is settled at the following falling edge
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
    @(negedge clk_sys_i);
    {reg_rd_i, reg_addr_i} = {1'h1, a};
    @(negedge clk_sys_i);
    reg_rd_i = 1'h0;
    chk(nm, reg_rdata_o, e);
  endtask
  task automatic ev(logic [14:0] b);
    @(negedge clk_sys_i);
    irq_event_i = b;
    @(negedge clk_sys_i);
    irq_event_i = 15'h0;
    @(negedge clk_sys_i);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk_sys_i);
    {rst_i, por_i} = 2'h0;
    rchk("nac reset", OFS_NAC, NAC_RST);
    rchk("spc reset", OFS_SPC, 32'h000C_000E);
    rchk("unmapped", 8'h04, 32'h0);
    chk("sqe test", sqe_test_en_o, 32'h0);
    $display("reset values done");
    wr(OFS_NAC, 32'hFFFF_F7FF);
    rchk("nac", OFS_NAC, 32'h0008_F4EA);
    chk("threshold", tx_fifo_threshold_o, 32'h3);
    chk("tx run", tx_run_o, 32'h1);
    chk("collide", forced_collide_o, 32'h1);
    chk("mode", loopback_select_o, 32'h1);
    chk("any good", {all_group_accept_o, accept_any_good_o}, 32'h3);
    chk("bad pass", bad_frame_accept_o, 32'h1);
    chk("hold idle", backoff_hold_o, 32'h0);
    carrier_i = 1'h1;
    @(negedge clk_sys_i);
    chk("hold busy", backoff_hold_o, 32'h1);
    carrier_i = 1'h0;
    chk("rx on", rx_active_o, 32'h1);
    // only the run bits change while the processes run; starred fields keep their value
    wr(OFS_NAC, 32'h0008_D4E8);
    chk("tx stop", {tx_run_o, forced_collide_o}, 32'h0);
    @(negedge clk_sys_i);
    chk("rx drains", rx_active_o, 32'h1);
    rx_frame_end_i = 1'h1;
    @(negedge clk_sys_i);
    rx_frame_end_i = 1'h0;
    repeat (2) @(negedge clk_sys_i);
    chk("rx off", rx_active_o, 32'h0);
    wr(OFS_NAC, 32'h0);
    chk("sqe on", sqe_test_en_o, 32'h1);
    $display("network access done");
    wr(OFS_IEM, 32'h0001_0001);
    ev(15'h0001);
    chk("irq normal", irq_o, 32'h1);
    wr(OFS_ISTS, 32'h1);
    chk("irq cleared", irq_o, 32'h0);
    wr(OFS_IEM, 32'h0000_0002);
    ev(15'h0002);
    chk("irq no group", irq_o, 32'h0);
    wr(OFS_IEM, 32'h0000_8002);
    rchk("iem", OFS_IEM, 32'h0000_8002);
    chk("irq abnormal", irq_o, 32'h1);
    wr(OFS_ISTS, 32'h2);
    chk("irq cleared", irq_o, 32'h0);
    $display("interrupt done");
    repeat (3) begin
      @(negedge clk_sys_i);
      drop_frame_i = 1'h1;
      @(negedge clk_sys_i);
      drop_frame_i = 1'h0;
    end
    rchk("dropped", OFS_DFC, 32'h3);
    rchk("dropped clr", OFS_DFC, 32'h0);
    $display("dropped count done");
    wr(OFS_SPC, 32'h0003_6807);
    chk("mgmt pins", {mdc_o, mdio_out_o, mdio_oe_n_o}, 32'h6);
    chk("ee pins", {ee_cs_o, ee_clk_o, ee_din_o}, 32'h7);
    rchk("spc", OFS_SPC, 32'h000B_680F);
    wr(OFS_SPC, 32'h0003_6801);
    wr(OFS_SPC, 32'h0003_6803);
    rchk("ee return", OFS_SPC, 32'h000B_6803);
    wr(OFS_SPC, 32'h0000_0003);
    chk("ee unselected", ee_cs_o, 32'h0);
    $display("serial pins done");
    wr(OFS_TMR, 32'h0001_0001);
    n = 0;
    // two reloads of a one-tick load fit in two ticks plus slack
    repeat (2 * TICK_CYC + 40) begin
      @(negedge clk_sys_i);
      if (timer_expired_o === 1'h1) n++;
    end
    chk("timer expiries", n, 32'h2);
    wr(OFS_TMR, 32'h0);
    $display("timer done");
    wr(OFS_WCS, 32'h6001_0100);
    chk("seed one", crc_seed_o, CRC_SEED_ONE);
    chk("pattern en", pattern_enable_o, 32'h10);
    link_up_i = 1'h1;
    repeat (3) @(negedge clk_sys_i);
    rchk("link rise", OFS_WCS, 32'h6001_0101);
    chk("pm event", pm_event_o, 32'h1);
    rst_i = 1'h1;
    @(negedge clk_sys_i);
    rst_i = 1'h0;
    rchk("wake kept", OFS_WCS, 32'h1);
    chk("seed zero", crc_seed_o, CRC_SEED_ZERO);
    wr(OFS_WCS, 32'h1);
    rchk("wake clr", OFS_WCS, 32'h0);
    wr(OFS_WCS, 32'h0002_0000);
    link_up_i = 1'h0;
    repeat (3) @(negedge clk_sys_i);
    rchk("link drop", OFS_WCS, 32'h0002_0001);
    $display("wake control done");
    for (int i = 0; i < WPT_WORDS; i++) wr(OFS_WPP, 32'hA500_0000 + i);
    wr(OFS_WPP, 32'h1234_5678);
    pat_raddr_i = 5'h00;
    repeat (2) @(negedge clk_sys_i);
    chk("pattern wrap", pat_rdata_o, 32'h1234_5678);
    wr(OFS_WAUX, 32'h40);
    wr(OFS_WAUX, 32'h0);
    wr(OFS_WPP, 32'h5A00_0001);
    wr(OFS_WPP, 32'h5A00_0002);
    for (int i = 0; i < WPT_WORDS; i++) begin
      pat_raddr_i = 5'(i);
      repeat (2) @(negedge clk_sys_i);
      chk("pattern", pat_rdata_o, i < 2 ? 32'h5A00_0001 + i : 32'hA500_0000 + i);
    end
    $display("pattern table done");
    give_verdict();
  end

  initial begin
    repeat (20000) @(negedge clk_sys_i);
    num_errors++;
    give_verdict();
  end
endmodule
